// [uftlf_pkg.sv]
package uftlf_pkg;

  // ****************************************
  // register map
  // ****************************************
  // addresses 0..2 are shared: data/mask/status or the three divisor bytes
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_LFC = 4'h3;
  localparam logic [3:0] ADDR_FSW = 4'h4;
  localparam logic [3:0] ADDR_FCW = 4'h5;
  localparam logic [3:0] ADDR_EFR = 4'h6;
  localparam logic [3:0] ADDR_RXTL = 4'h7;
  localparam logic [3:0] ADDR_TXTL = 4'h8;
  localparam logic [3:0] ADDR_LSTAT = 4'h9;
  localparam logic [3:0] ADDR_RXCNT = 4'hA;
  localparam logic [3:0] ADDR_TXCNT = 4'hB;

  // ****************************************
  // field positions
  // ****************************************
  localparam int FSW_EN = 0;
  localparam int FSW_TXSEL = 4;
  localparam int FSW_RXSEL = 6;
  localparam int LFC_WLS = 0;
  localparam int LFC_STB = 2;
  localparam int LFC_PEN = 3;
  localparam int LFC_EPS = 4;
  localparam int LFC_STICK = 5;
  localparam int LFC_BRK = 6;
  localparam int LFC_DLAB = 7;
  localparam int FCW_TBL = 6;
  localparam int EFR_ENH = 4;
  localparam int IRQ_RECEIVE_TRIGGER_LEVEL_REG = 0;
  localparam int IRQ_TRANSMIT_TRIGGER_LEVEL_REG = 1;
  localparam int IRQ_PAR = 2;
  localparam int IRQ_FRM = 3;
  localparam int IRQ_OVR = 4;
  localparam int IRQ_W = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [7:0] FCW_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] TL_RST = 8'h01;
  localparam logic [7:0] DIVL_RST = 8'h01;
  localparam logic [7:0] DIVH_RST = 8'h00;
  localparam logic [7:0] DIVF_RST = 8'h00;
  localparam logic [7:0] LEVEL_SOLO = 8'h01;

  // ****************************************
  // bit timing in 16x ticks
  // ****************************************
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_STOP_1 = 6'h10;
  localparam logic [5:0] TICKS_STOP_15 = 6'h18;
  localparam logic [5:0] TICKS_STOP_2 = 6'h20;

  // ****************************************
  // trigger tables, rows by table, columns by select
  // ****************************************
  // row 3 is never used: that table takes levels from registers
  localparam logic [7:0] RX_LEVELS [0:3][0:3] = '{
    '{8'h01, 8'h04, 8'h08, 8'h0E},
    '{8'h08, 8'h10, 8'h18, 8'h1C},
    '{8'h08, 8'h10, 8'h38, 8'h3C},
    '{8'h01, 8'h01, 8'h01, 8'h01}};
  localparam logic [7:0] TX_LEVELS [0:3][0:3] = '{
    '{8'h01, 8'h01, 8'h01, 8'h01},
    '{8'h10, 8'h08, 8'h18, 8'h1E},
    '{8'h08, 8'h10, 8'h20, 8'h38},
    '{8'h01, 8'h01, 8'h01, 8'h01}};

  typedef enum logic [2:0] {LN_IDLE, LN_START, LN_DATA, LN_PAR, LN_STOP} uftlf_line_e;

  function automatic logic uftlf_par(input logic [7:0] d, input logic [1:0] wls,
                                      input logic eps, input logic stick);
    logic [7:0] m;
    m = d & (8'hFF >> (3'd3 - {1'b0, wls}));
    return stick ? ~eps : (^m ^ ~eps);
  endfunction

endpackage

// [uftlf_fifo_if.sv]
`timescale 1ns/100ps
interface uftlf_fifo_if #(parameter int W = 10, parameter int AW = 8);
  logic push;
  logic pop;
  logic flush;
  logic solo;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [AW:0] count;
  logic full;
  logic empty;
  modport store(input push, pop, flush, solo, wdata, output rdata, count, full, empty);
  modport reader(output pop, input rdata, empty);
endinterface

// [uftlf_fifo.sv]
`timescale 1ns/100ps
module uftlf_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  uftlf_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  wire do_push = f.push & ~f.full;
  wire do_pop = f.pop & ~f.empty;
  // in non-FIFO mode the store acts as a single holding register
  assign f.full = f.solo ? (cnt_q != '0) : (cnt_q == (AW+1)'(DEPTH)); // RQ1
  assign f.empty = (cnt_q == '0);
  assign f.count = cnt_q;
  assign f.rdata = mem[rp_q];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_q] <= f.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (f.flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(do_push);
      rp_q <= rp_q + AW'(do_pop);
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// [uftlf_tx.sv]
`timescale 1ns/100ps
module uftlf_tx
  import uftlf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [7:0] lfc,
  uftlf_fifo_if.reader f,
  output logic txd,
  output logic busy
);
  uftlf_line_e st_q;
  logic [7:0] sh_q;
  logic par_q;
  logic [2:0] bit_q;
  logic [5:0] tk_q;
  logic line_q;
  logic txd_q;
  wire [1:0] wls = lfc[LFC_WLS +: 2];
  wire [2:0] last_bit = 3'd4 + {1'b0, wls}; // RQ13
  // 5-bit words stretch to 1.5 stop bits, longer words to 2
  wire [5:0] stop_ticks = !lfc[LFC_STB] ? TICKS_STOP_1 :
                          (wls == 2'b00) ? TICKS_STOP_15 : TICKS_STOP_2; // RQ12
  wire [5:0] limit = (st_q == LN_STOP) ? stop_ticks : TICKS_BIT;
  wire bit_end = tick & (tk_q == limit - 6'd1);
  // reloading at the end of the stop bit keeps back-to-back frames free of an idle clock
  wire load = ((st_q == LN_IDLE) | ((st_q == LN_STOP) & bit_end)) & ~f.empty; // RQ12
  assign f.pop = load;
  assign busy = (st_q != LN_IDLE);
  assign txd = txd_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= LN_IDLE;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      bit_q <= 3'd0;
      tk_q <= 6'd0;
      line_q <= 1'b1;
      txd_q <= 1'b1;
    end else begin
      txd_q <= line_q & ~lfc[LFC_BRK]; // RQ8
      if (st_q == LN_IDLE) begin
        tk_q <= 6'd0;
      end else if (bit_end) begin
        tk_q <= 6'd0;
      end else if (tick) begin
        tk_q <= tk_q + 6'd1;
      end
      case (st_q)
        LN_IDLE: begin
          st_q <= LN_IDLE;
        end
        LN_START: begin
          if (bit_end) begin
            line_q <= sh_q[0];
            st_q <= LN_DATA;
          end
        end
        LN_DATA: begin
          if (bit_end) begin
            if (bit_q == last_bit) begin
              line_q <= lfc[LFC_PEN] ? par_q : 1'b1; // RQ9
              st_q <= lfc[LFC_PEN] ? LN_PAR : LN_STOP;
            end else begin
              line_q <= sh_q[1];
              sh_q <= {1'b0, sh_q[7:1]};
              bit_q <= bit_q + 3'd1;
            end
          end
        end
        LN_PAR: begin
          if (bit_end) begin
            line_q <= 1'b1;
            st_q <= LN_STOP;
          end
        end
        LN_STOP: begin
          if (bit_end) begin
            st_q <= LN_IDLE;
          end
        end
        default: begin
          st_q <= LN_IDLE;
        end
      endcase
      if (load) begin
        sh_q <= f.rdata;
        par_q <= uftlf_par(f.rdata, wls, lfc[LFC_EPS], lfc[LFC_STICK]); // RQ10 RQ11
        bit_q <= 3'd0;
        line_q <= 1'b0;
        st_q <= LN_START;
      end
    end
  end
endmodule

// [uftlf_core.sv]
// Behaviour
// RQ1: fifo enable resets to 0 (no FIFOs); 1 enables both 256-entry FIFOs together.
// RQ2: other fifo setup fields change only on a write that also sets enable.
// RQ3: table 0 gives receive levels 1,4,8,14; transmit level fixed at 1.
// RQ4: table 1 gives receive 8,16,24,28 and transmit 16,8,24,30.
// RQ5: table 2 gives receive 8,16,56,60 and transmit 8,16,32,56.
// RQ6: table 3 ignores select fields; levels come from the two level registers.
// RQ7: divisor access bit 1 maps shared addresses to the three divisor bytes.
// RQ8: break bit holds the transmit output low until cleared; resets clear.
// RQ9: parity disabled means no parity bit sent or checked.
// RQ10: unforced parity: select 0 odd (reset), 1 even, both directions.
// RQ11: forced parity: select 0 gives mark, select 1 gives space.
// RQ12: stop-length 1 gives 1.5 stops at 5 bits, else 2; 0 gives 1.
// RQ13: word length field picks 5 to 8 data bits; reset picks 5.
// RQ14: receive count crossing the receive level raises a receive event.
// RQ15: one table selection serves both directions.
// RQ16: transmit select acts only with the enhanced-function bit set.
// RQ17: table and selects reset to zero, giving levels of one character.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
module uftlf_core
  import uftlf_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);

  // ****************************************
  // software registers
  // ****************************************
  logic [7:0] lfc_q;
  logic fsw_en_q;
  logic [1:0] rxsel_q;
  logic [1:0] txsel_q;
  logic [7:0] fcw_q;
  logic [7:0] efr_q;
  logic [7:0] rxtl_q;
  logic [7:0] txtl_q;
  logic [7:0] divl_q;
  logic [7:0] divh_q;
  logic [7:0] divf_q;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] stat_q;
  logic [7:0] rdata_q;

  uftlf_fifo_if #(.W(10), .AW(AW)) rxf();
  uftlf_fifo_if #(.W(8), .AW(AW)) txf();

  wire dlab = lfc_q[LFC_DLAB];
  wire sh_data = (addr == ADDR_DATA) & ~dlab; // RQ7
  wire sh_mask = (addr == ADDR_MASK) & ~dlab;
  wire sh_stat = (addr == ADDR_STAT) & ~dlab;
  wire sh_divl = (addr == ADDR_DATA) & dlab; // RQ7
  wire sh_divh = (addr == ADDR_MASK) & dlab;
  wire sh_divf = (addr == ADDR_STAT) & dlab;
  wire wr_fsw = wr & (addr == ADDR_FSW);
  wire fsw_toggle = wr_fsw & (wdata[FSW_EN] != fsw_en_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfc_q <= LFC_RST;
      fcw_q <= FCW_RST;
      efr_q <= EFR_RST;
      rxtl_q <= TL_RST;
      txtl_q <= TL_RST;
      divl_q <= DIVL_RST;
      divh_q <= DIVH_RST;
      divf_q <= DIVF_RST;
      mask_q <= '0;
    end else if (wr) begin
      if (addr == ADDR_LFC) lfc_q <= wdata;
      if (addr == ADDR_FCW) fcw_q <= wdata;
      if (addr == ADDR_EFR) efr_q <= wdata;
      if (addr == ADDR_RXTL) rxtl_q <= wdata;
      if (addr == ADDR_TXTL) txtl_q <= wdata;
      if (sh_divl) divl_q <= wdata;
      if (sh_divh) divh_q <= wdata;
      if (sh_divf) divf_q <= wdata;
      if (sh_mask) mask_q <= wdata[IRQ_W-1:0];
    end
  end

  // ****************************************
  // fifo setup word (write only)
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsw_en_q <= 1'b0; // RQ1
      rxsel_q <= 2'b00; // RQ17
      txsel_q <= 2'b00;
    end else if (wr_fsw) begin
      fsw_en_q <= wdata[FSW_EN]; // RQ1
      if (wdata[FSW_EN]) begin
        rxsel_q <= wdata[FSW_RXSEL +: 2]; // RQ2
      end
      if (wdata[FSW_EN] && efr_q[EFR_ENH]) begin
        txsel_q <= wdata[FSW_TXSEL +: 2]; // RQ2 RQ16
      end
    end
  end

  // ****************************************
  // trigger levels
  // ****************************************
  // a single table field feeds both directions
  wire [1:0] tbl = fcw_q[FCW_TBL +: 2]; // RQ15
  wire [1:0] txsel_eff = efr_q[EFR_ENH] ? txsel_q : 2'b00; // RQ16
  wire [7:0] rx_tab = RX_LEVELS[tbl][rxsel_q]; // RQ3 RQ4 RQ5
  wire [7:0] tx_tab = TX_LEVELS[tbl][txsel_eff]; // RQ3 RQ4 RQ5
  wire [7:0] rx_lvl = !fsw_en_q ? LEVEL_SOLO : (tbl == 2'b11) ? rxtl_q : rx_tab; // RQ6
  wire [7:0] tx_lvl = !fsw_en_q ? LEVEL_SOLO : (tbl == 2'b11) ? txtl_q : tx_tab; // RQ6

  // ****************************************
  // fifos
  // ****************************************
  // changing the enable flushes both stores so no stale data spans modes
  assign rxf.flush = fsw_toggle;
  assign txf.flush = fsw_toggle;
  assign rxf.solo = ~fsw_en_q; // RQ1
  assign txf.solo = ~fsw_en_q; // RQ1
  assign rxf.pop = rd & sh_data;
  assign txf.push = wr & sh_data;
  assign txf.wdata = wdata;

  uftlf_fifo #(.W(10), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .f(rxf)
  );

  uftlf_fifo #(.W(8), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .f(txf)
  );

  // ****************************************
  // baud tick (16x)
  // ****************************************
  // the fraction byte is held for software only; the count is integral
  logic [15:0] bcnt_q;
  wire [15:0] div = {divh_q, divl_q};
  wire tick = (div != 16'h0000) & (bcnt_q == 16'h0000);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q <= 16'h0000;
    end else if (div == 16'h0000) begin
      bcnt_q <= 16'h0000;
    end else if (bcnt_q == 16'h0000) begin
      bcnt_q <= div - 16'h0001;
    end else begin
      bcnt_q <= bcnt_q - 16'h0001;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic tx_busy;

  uftlf_tx u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .lfc(lfc_q),
    .f(txf),
    .txd(txd),
    .busy(tx_busy)
  );

  // ****************************************
  // receiver
  // ****************************************
  uftlf_line_e rst_q;
  logic [7:0] rsh_q;
  logic rpar_q;
  logic [2:0] rbit_q;
  logic [5:0] rtk_q;
  wire [1:0] wls = lfc_q[LFC_WLS +: 2];
  wire [2:0] last_bit = 3'd4 + {1'b0, wls}; // RQ13
  wire [2:0] align = 3'd3 - {1'b0, wls};
  wire [7:0] rx_word = rsh_q >> align; // RQ13
  wire samp = tick & (rtk_q == TICKS_BIT - 6'd1);
  wire mid_start = tick & (rtk_q == TICKS_HALF - 6'd1);
  wire rx_par_ok = rpar_q == uftlf_par(rx_word, wls, lfc_q[LFC_EPS], lfc_q[LFC_STICK]);
  wire rx_pe = lfc_q[LFC_PEN] & ~rx_par_ok; // RQ9 RQ10 RQ11
  // only the first stop bit is checked; a longer stop is not required inbound
  wire rx_done = (rst_q == LN_STOP) & samp;
  wire rx_fe = ~rxd;
  assign rxf.push = rx_done;
  assign rxf.wdata = {rx_fe, rx_pe, rx_word};
  wire ovr_ev = rx_done & rxf.full;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= LN_IDLE;
      rsh_q <= 8'h00;
      rpar_q <= 1'b0;
      rbit_q <= 3'd0;
      rtk_q <= 6'd0;
    end else begin
      if (rst_q == LN_IDLE || mid_start && rst_q == LN_START || samp) begin
        rtk_q <= 6'd0;
      end else if (tick) begin
        rtk_q <= rtk_q + 6'd1;
      end
      case (rst_q)
        LN_IDLE: begin
          if (!rxd) begin
            rst_q <= LN_START;
          end
        end
        LN_START: begin
          if (mid_start) begin
            rbit_q <= 3'd0;
            rst_q <= rxd ? LN_IDLE : LN_DATA;
          end
        end
        LN_DATA: begin
          if (samp) begin
            rsh_q <= {rxd, rsh_q[7:1]};
            rbit_q <= rbit_q + 3'd1;
            if (rbit_q == last_bit) begin
              rst_q <= lfc_q[LFC_PEN] ? LN_PAR : LN_STOP; // RQ9
            end
          end
        end
        LN_PAR: begin
          if (samp) begin
            rpar_q <= rxd;
            rst_q <= LN_STOP;
          end
        end
        LN_STOP: begin
          if (samp) begin
            rst_q <= LN_IDLE;
          end
        end
        default: begin
          rst_q <= LN_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // events and interrupt
  // ****************************************
  logic rx_at_q;
  logic tx_below_q;
  logic tx_empty_q;
  wire rx_at = rxf.count >= (AW+1)'(rx_lvl);
  wire tx_below = txf.count < (AW+1)'(tx_lvl);
  wire rx_ev = rx_at & ~rx_at_q; // RQ14
  wire tx_ev = (tx_below & ~tx_below_q) | (txf.empty & ~tx_empty_q);
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_RECEIVE_TRIGGER_LEVEL_REG] = rx_ev; // RQ14
  assign ev[IRQ_TRANSMIT_TRIGGER_LEVEL_REG] = tx_ev;
  assign ev[IRQ_PAR] = rx_done & rx_pe;
  assign ev[IRQ_FRM] = rx_done & rx_fe;
  assign ev[IRQ_OVR] = ovr_ev;
  wire stat_clr = rd & sh_stat;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_at_q <= 1'b0;
      tx_below_q <= 1'b1;
      tx_empty_q <= 1'b1;
      stat_q <= '0;
    end else begin
      rx_at_q <= rx_at;
      tx_below_q <= tx_below;
      tx_empty_q <= txf.empty;
      // a new event wins over the read that clears
      stat_q <= (stat_q & ~{IRQ_W{stat_clr}}) | ev;
    end
  end

  assign irq = |(stat_q & mask_q);

  // ****************************************
  // read path
  // ****************************************
  wire [7:0] lstat = {~tx_busy & txf.empty, txf.empty, fsw_en_q, 2'b00,
                      rxf.rdata[9], rxf.rdata[8], ~rxf.empty};
  wire [7:0] rd_mux =
    sh_data ? rxf.rdata[7:0] :
    sh_divl ? divl_q :
    sh_divh ? divh_q :
    sh_divf ? divf_q :
    sh_mask ? 8'(mask_q) :
    sh_stat ? 8'(stat_q) :
    (addr == ADDR_LFC) ? lfc_q :
    (addr == ADDR_FCW) ? fcw_q :
    (addr == ADDR_EFR) ? efr_q :
    (addr == ADDR_RXTL) ? rxtl_q :
    (addr == ADDR_TXTL) ? txtl_q :
    (addr == ADDR_LSTAT) ? lstat :
    (addr == ADDR_RXCNT) ? rxf.count[AW:1] :
    (addr == ADDR_TXCNT) ? txf.count[AW:1] : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd ? rd_mux : 8'h00;
    end
  end

  assign rdata = rdata_q;
endmodule

// [uftlf_core_properties.sv]
`timescale 1ns/100ps
module uftlf_core_checker
  import uftlf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  // ****************************************
  // shadow copies of written registers
  // ****************************************
  logic [7:0] lfc_q;
  logic [7:0] divl_q;
  logic [4:0] mask_q;
  logic fen_q;
  wire wr_lfc = wr && addr == ADDR_LFC;
  wire wr_div = wr && addr == ADDR_DATA && lfc_q[LFC_DLAB];
  wire wr_mask = wr && addr == ADDR_MASK && !lfc_q[LFC_DLAB];
  wire wr_fsw = wr && addr == ADDR_FSW;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfc_q <= LFC_RST;
      divl_q <= DIVL_RST;
      mask_q <= 5'h00;
      fen_q <= 1'b0;
    end else begin
      if (wr_lfc) lfc_q <= wdata;
      if (wr_div) divl_q <= wdata;
      if (wr_mask) mask_q <= wdata[4:0];
      if (wr_fsw) fen_q <= wdata[FSW_EN];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // sequences
  // ****************************************
  sequence s_rd(logic [3:0] a);
    rd && addr == a;
  endsequence
  sequence s_brk_on;
    wr && addr == ADDR_LFC && wdata[LFC_BRK];
  endsequence

  // ****************************************
  // properties
  // ****************************************
  a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_setup_write_only: assert property (s_rd(ADDR_FSW) |=> rdata == 8'h00)
    else $error("fifo setup word read back nonzero");
  a_format_readback: assert property (s_rd(ADDR_LFC) |=> rdata == $past(lfc_q))
    else $error("line format readback mismatch");
  a_divisor_view: assert property (s_rd(ADDR_DATA) ##0 lfc_q[LFC_DLAB] |=>
    rdata == $past(divl_q))
    else $error("divisor low not seen at shared address");
  a_fifo_status: assert property (s_rd(ADDR_LSTAT) |=> rdata[5] == $past(fen_q))
    else $error("fifo enable status mismatch");
  a_irq_masked: assert property (mask_q == 5'h00 |-> !irq)
    else $error("interrupt with all sources masked");
  a_break_start: assert property (s_brk_on |-> ##2 !txd)
    else $error("break did not pull transmit low");
  a_break_hold: assert property (lfc_q[LFC_BRK] && $past(lfc_q[LFC_BRK]) |-> !txd)
    else $error("transmit high during break");
  a_idle_reset: assert property ($rose(rst_n) |-> txd && !irq)
    else $error("outputs not idle after reset");
endmodule

bind uftlf_core uftlf_core_checker u_chk (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));

// [uftlf_remote.sv]
`timescale 1ns/100ps
module uftlf_remote (
  input wire logic clk,
  input wire logic txd,
  input wire logic [3:0] ncap,
  output logic rxd
);
  // divisor stays at its reset value, so one bit is 16 clocks
  localparam int BITC = 16;
  logic [11:0] cap;
  logic last;
  int gap;
  int cyc;
  int t0;

  initial begin
    rxd = 1'b1;
    last = 1'b1;
    cap = 12'h000;
    cyc = 0;
    t0 = 0;
    gap = 0;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // sample mid-bit; gap is start-to-start, so it also measures the stop length
  // starts are found on clock edges, and no wait follows the last sample,
  // so a start bit that comes right after the stop bit is still caught
  always begin
    @(posedge clk);
    if (last && !txd) begin
      gap = cyc - t0;
      t0 = cyc;
      repeat (BITC / 2) @(posedge clk);
      for (int i = 0; i < ncap; i++) begin
        if (i > 0) begin
          repeat (BITC) @(posedge clk);
        end
        cap[i] = txd;
      end
    end
    last = txd;
  end

  // bits go out lsb first; the line is left at mark after the stop bit
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BITC) @(posedge clk);
    end
  endtask
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  import uftlf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rxd;
  logic txd;
  logic irq;
  logic [3:0] ncap = 4'h7;
  logic [7:0] rv;
  logic [7:0] lfc;
  logic [11:0] msk;
  int n;
  int pen;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] lv [13] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h08, 8'h10, 8'h18, 8'h1C,
    8'h08, 8'h10, 8'h38, 8'h3C, 8'h05};
  logic [7:0] fmts [8] = '{8'h00, 8'h04, 8'h07, 8'h0B, 8'h1A, 8'h29, 8'h3D, 8'h33};

  uftlf_core #(.DEPTH(256)) uut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
  uftlf_remote peer (.clk(clk), .txd(txd), .ncap(ncap), .rxd(rxd));

  always #5 clk = ~clk;

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    rd_reg(a, rv);
    check({8'h00, rv}, {8'h00, exp});
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // start bit, masked data lsb first, optional parity, first stop bit
  function automatic logic [11:0] tx_frame(input logic [7:0] f, input logic [7:0] d);
    int w;
    logic [7:0] m;
    logic [11:0] r;
    w = 5 + int'(f[1:0]);
    m = d & (8'hFF >> (8 - w));
    r = {3'h0, m, 1'b0};
    r[w + 1] = f[5] ? ~f[4] : (f[4] ? ^m : ~^m);
    r[w + 1 + int'(f[3])] = 1'b1;
    return r;
  endfunction

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // ****************************************
    // reset values and address map
    // ****************************************
    rd_chk(ADDR_LFC, 8'h00);
    rd_chk(ADDR_FCW, 8'h00);
    rd_chk(ADDR_RXTL, TL_RST);
    rd_chk(ADDR_FSW, 8'h00);
    rd_reg(ADDR_LSTAT, rv);
    check(rv[5], 1'b0);
    rd_chk(4'hC, 8'h00);
    wr_reg(ADDR_MASK, 8'h01);
    wr_reg(ADDR_LFC, 8'h80);
    rd_chk(ADDR_DATA, DIVL_RST);
    rd_chk(ADDR_MASK, DIVH_RST);
    rd_chk(ADDR_STAT, DIVF_RST);
    wr_reg(ADDR_LFC, 8'h00);
    rd_chk(ADDR_MASK, 8'h01);
    // ****************************************
    // receive trigger levels of all tables
    // ****************************************
    wr_reg(ADDR_RXTL, 8'h05);
    for (int k = 0; k < 13; k++) begin
      wr_reg(ADDR_FCW, {k[3:2], 6'h00});
      wr_reg(ADDR_FSW, {k[1:0], 5'h00, 1'b1});
      rd_reg(ADDR_STAT, rv);
      for (int i = 0; i < lv[k]; i++) begin
        if (i == lv[k] - 1) begin
          repeat (8) @(posedge clk);
          check(irq, 1'b0);
        end
        peer.send({6'h3F, i[4:0], 1'b0}, 7);
      end
      repeat (8) @(posedge clk);
      check(irq, 1'b1);
      wr_reg(ADDR_MASK, 8'h00);
      check(irq, 1'b0);
      wr_reg(ADDR_MASK, 8'h01);
      check(irq, 1'b1);
      rd_reg(ADDR_STAT, rv);
      check(rv[IRQ_RECEIVE_TRIGGER_LEVEL_REG], 1'b1);
      check(irq, 1'b0);
      for (int i = 0; i < lv[k]; i++) begin
        rd_chk(ADDR_DATA, {3'h0, i[4:0]});
      end
      rd_chk(ADDR_RXCNT, 8'h00);
    end
    rd_reg(ADDR_LSTAT, rv);
    check(rv[5], 1'b1);
    // ****************************************
    // transmit formats, two frames back to back
    // ****************************************
    foreach (fmts[k]) begin
      lfc = fmts[k];
      n = 5 + int'(lfc[1:0]);
      pen = int'(lfc[3]);
      ncap <= 4'(2 + n + pen);
      msk = (12'h001 << (2 + n + pen)) - 12'h001;
      wr_reg(ADDR_LFC, lfc);
      wr_reg(ADDR_DATA, 8'hA5);
      wr_reg(ADDR_DATA, 8'hA5);
      repeat (400) @(posedge clk);
      check({4'h0, peer.cap & msk}, {4'h0, tx_frame(lfc, 8'hA5) & msk});
      check(peer.gap[15:0], 16'(16 * (1 + n + pen) + (lfc[2] ? (n == 5 ? 24 : 32) : 16)));
    end
    // ****************************************
    // break
    // ****************************************
    wr_reg(ADDR_LFC, 8'h40);
    repeat (4) @(posedge clk);
    check(txd, 1'b0);
    repeat (60) @(posedge clk);
    check(txd, 1'b0);
    wr_reg(ADDR_LFC, 8'h00);
    repeat (200) @(posedge clk);
    check(txd, 1'b1);
    // ****************************************
    // transmit trigger level through the enhanced bit
    // ****************************************
    wr_reg(ADDR_EFR, 8'h10);
    wr_reg(ADDR_FCW, 8'h40);
    wr_reg(ADDR_FSW, 8'h11);
    for (int i = 0; i < 9; i++) begin
      wr_reg(ADDR_DATA, 8'h5A);
    end
    rd_reg(ADDR_STAT, rv);
    rd_reg(ADDR_STAT, rv);
    check(rv[IRQ_TRANSMIT_TRIGGER_LEVEL_REG], 1'b0);
    repeat (120) @(posedge clk);
    rd_reg(ADDR_STAT, rv);
    check(rv[IRQ_TRANSMIT_TRIGGER_LEVEL_REG], 1'b1);
    print_verdict();
  end
endmodule
